// *** hw/ebf_formatter.sv ***
// Behaviour
// (RL1) Event buffer is a read-only window at offsets 0x0000 to 0x07FC.
// (RL2) Each window read returns one whole 32-bit buffer word.
// (RL3) An event is a header, one or more data words, then a trailer.
// (RL4) Slot address sits in bits 31..27 of all words except the filler.
// (RL5) Type bits 26..24: 010 header, 000 data, 100 trailer, 110 filler.
// (RL6) Header bits 23..16 carry the configured crate number.
// (RL7) Header bits 13..8 carry the number of data words stored.
// (RL8) Channel in bits 20..16, or 20..17 on the reduced variant.
// (RL9) Data bit 13 flags a value below its channel threshold.
// (RL10) Below-threshold values are stored only if control bits allow it.
// (RL11) Data bit 12 flags converter overflow.
// (RL12) The 12-bit conversion result sits in data bits 11..0.
// (RL13) Trailer bits 23..0 carry the 24-bit event counter.
// (RL14) Reading an empty buffer returns the filler word, type 110.
// (RL15) Channels are stored interleaved: 0, 16, 1, 17 ... or 0, 8, 1, 9.
// (RL16) Overflowed, below-threshold or disabled channels are left out; the code keeps the first two when their set2 keep bits are set.
// (RL17) Each stored event goes to the next slot; write pointer moves one.
// (RL18) Without the auxiliary connector the master writes the slot address.
// (RL19) Slot address writes are taken only when the connector is absent.
// (RL20) Chained transfers answer only within window 0x0000 to 0x07FF.
// (RL21) Multicast accesses treat 0x1006 to 0x10BF as write-only.
// (RL22) Read-only 16-bit firmware revision register at 0x1000.
// (RL23) Offsets 0x8000 to 0xFFFF are read-only configuration memory.
// (RL24) Unassigned bits of header, data and trailer words are zero.
// (RL25) Each completed window read removes exactly one buffer word.
`timescale 1ns/1ps
`default_nettype none
`include "ebf_map.svh"

module ebf_formatter #(
  parameter bit          FULL_VARIANT = 1'b1,
  // Arbitrary revision value.
  parameter logic [15:0] FW_REVISION  = 16'h0A17
) (
  // Clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  // Register access port
  input  wire ebf_pkg::ebf_bus_req_t i_bus,
  output logic [31:0]                o_rdata,
  output logic                       o_ack,
  // Conversion results
  input  wire ebf_pkg::ebf_conv_t    i_conv,
  input  wire logic [31:0]           i_chan_off,
  output logic                       o_conv_ready,
  // Backplane pins
  input  wire logic                  i_auxiliary_slot_connector,
  input  wire logic [4:0]            i_slot_pins,
  // Status
  output logic                       o_data_ready
);
  import ebf_pkg::*;

  localparam int SB = `EBF_SLOT_BITS;
  localparam int WB = `EBF_WORD_BITS;

  // Pin synchronisers.
  logic       aux_s1_reg;
  logic       aux_s2_reg;
  logic [4:0] pins_s1_reg;
  logic [4:0] pins_s2_reg;
  logic [1:0] strap_cnt_reg;
  logic       strap_done_reg;

  // Configuration state.
  logic [4:0]  slot_reg;
  logic [7:0]  crate_reg;
  logic [15:0] set2_reg;
  logic [23:0] evcnt_reg;

  // Buffer pointers.
  logic [SB:0]   wslot_reg;
  logic [SB:0]   rslot_reg;
  logic [WB-1:0] rword_reg;
  logic          pend_reg;

  // Event assembly.
  ebf_fill_st_t fill_reg;
  ebf_fill_st_t fill_next;
  ebf_conv_t    conv_reg;
  logic [31:0]  off_reg;
  logic [4:0]   idx_reg;
  logic [5:0]   cnt_reg;

  // Output flops.
  logic [31:0] rdata_reg;
  logic        ack_reg;
  logic        ready_reg;
  logic        dready_reg;

  logic [31:0] mem_q;

  wire logic slot_address_missing = ~aux_s2_reg;

  // Pointer status.
  wire logic empty = (wslot_reg == rslot_reg);
  wire logic full  = (wslot_reg[SB-1:0] == rslot_reg[SB-1:0]) && (wslot_reg[SB] != rslot_reg[SB]);

  // Channel order and keep decision.
  wire logic [4:0] last_idx = FULL_VARIANT ? 5'h1F : 5'h0F;
  wire logic [4:0] chan     = FULL_VARIANT ? {idx_reg[0], idx_reg[4:1]}
                                           : {1'b0, idx_reg[0], idx_reg[3:1]}; // see RL15
  logic [31:0] keep_vec;

  genvar c;
  generate
    for (c = 0; c < 32; c++) begin : g_keep
      assign keep_vec[c] = ~off_reg[c]
                         & (~conv_reg.ovf[c] | set2_reg[`EBF_SET2_OVF_KEEP])
                         & (~conv_reg.below[c] | set2_reg[`EBF_SET2_BELOW_KEEP]); // see RL10 see RL16
    end
  endgenerate

  wire logic keep_now = (fill_reg == FILL_SCAN) && keep_vec[chan];
  wire logic scan_end = (fill_reg == FILL_SCAN) && (idx_reg == last_idx);
  wire logic accept   = (fill_reg == FILL_IDLE) && ready_reg && i_conv.valid;

  // Word builders.
  wire logic [4:0] chan_field = FULL_VARIANT ? chan : {chan[3:0], 1'b0}; // see RL8
  wire logic [31:0] data_word = {slot_reg, `EBF_TYPE_DATA, 3'h0, chan_field, 2'h0,
                                 conv_reg.below[chan], conv_reg.ovf[chan],
                                 conv_reg.value[chan]}; // see RL4 see RL9 see RL11 see RL12 see RL24
  wire logic [31:0] head_word = {slot_reg, `EBF_TYPE_HEAD, crate_reg, 2'h0,
                                 cnt_reg, 8'h00}; // see RL6 see RL7 see RL24
  wire logic [31:0] tail_word = {slot_reg, `EBF_TYPE_TAIL, evcnt_reg}; // see RL13
  wire logic [31:0] fill_word = {5'h00, `EBF_TYPE_FILL, 24'h000000}; // see RL14

  // Memory write port.
  wire logic [SB-1:0] wbase = wslot_reg[SB-1:0];
  wire logic [WB-1:0] dpos  = WB'(cnt_reg) + 6'h01;
  ebf_mem_wr_t mem_wr;
  assign mem_wr.en   = keep_now || (fill_reg == FILL_HEAD) || (fill_reg == FILL_TAIL);
  assign mem_wr.addr = (fill_reg == FILL_HEAD) ? {wbase, 6'h00} : {wbase, dpos};
  assign mem_wr.data = (fill_reg == FILL_HEAD) ? head_word
                     : (fill_reg == FILL_TAIL) ? tail_word : data_word; // see RL3 see RL5

  wire logic [`EBF_ADDR_BITS-1:0] mem_raddr = {rslot_reg[SB-1:0], rword_reg};

  ebf_word_mem u_mem (
    .i_clk   (i_clk),
    .i_wr    (mem_wr),
    .i_raddr (mem_raddr),
    .o_rdata (mem_q)
  );

  // Assembly sequencing.
  always_comb begin
    fill_next = fill_reg;
    case (fill_reg)
      FILL_IDLE: begin
        if (accept) begin
          fill_next = FILL_SCAN;
        end
      end
      FILL_SCAN: begin
        if (scan_end) begin
          fill_next = (cnt_reg == 6'h00 && !keep_now) ? FILL_IDLE : FILL_HEAD;
        end
      end
      FILL_HEAD: fill_next = FILL_TAIL;
      FILL_TAIL: fill_next = FILL_IDLE;
      default:   fill_next = FILL_IDLE;
    endcase
  end

  wire logic commit      = (fill_reg == FILL_TAIL);
  wire logic empty_event = scan_end && (cnt_reg == 6'h00) && !keep_now;
  wire logic [SB:0] wslot_next = commit ? wslot_reg + 1'b1 : wslot_reg; // see RL17
  wire logic full_next = (wslot_next[SB-1:0] == rslot_reg[SB-1:0]) && (wslot_next[SB] != rslot_reg[SB]);

  // Bus decode.
  wire logic [15:0] a      = i_bus.addr;
  wire logic in_win        = (a <= `EBF_OFS_WIN_END);
  wire logic in_mcst       = (a >= `EBF_OFS_MCST_FIRST) && (a <= `EBF_OFS_MCST_LAST);
  wire logic in_rom        = (a >= `EBF_OFS_ROM_FIRST);
  wire logic plain         = ~i_bus.chained & ~i_bus.mcst;
  wire logic win_rd        = i_bus.rd && in_win && ~i_bus.mcst && ~pend_reg; // see RL1 see RL20
  wire logic hit_fw        = (a == `EBF_OFS_FW_REV);
  wire logic hit_slot      = (a == `EBF_OFS_SLOT);
  wire logic hit_st1       = (a == `EBF_OFS_STATUS1);
  wire logic hit_evl       = (a == `EBF_OFS_EVCNT_LO);
  wire logic hit_evh       = (a == `EBF_OFS_EVCNT_HI);
  wire logic hit_set2      = (a == `EBF_OFS_SET2);
  wire logic hit_clr2      = (a == `EBF_OFS_CLR2);
  wire logic hit_crate     = (a == `EBF_OFS_CRATE);
  wire logic cfg_rd        = i_bus.rd && plain && ~pend_reg
                          && (hit_fw || hit_slot || hit_st1 || hit_evl || hit_evh
                              || hit_set2 || hit_crate || in_rom); // see RL22 see RL23
  wire logic slot_wr_ok    = hit_slot && slot_address_missing && plain; // see RL19
  wire logic cfg_wr        = i_bus.wr && ~i_bus.chained && ~pend_reg
                          && (i_bus.mcst ? in_mcst
                                         : (slot_wr_ok || hit_set2 || hit_clr2 || hit_crate)); // see RL21
  wire logic [15:0] status1 = {11'h000, slot_address_missing, 1'b0,
                               (fill_reg != FILL_IDLE) || full, 1'b0, ~empty};
  wire logic [15:0] cfg_data =
      in_rom    ? 16'h0000 :
      hit_fw    ? FW_REVISION :
      hit_slot  ? {11'h000, slot_reg} :
      hit_st1   ? status1 :
      hit_evl   ? evcnt_reg[15:0] :
      hit_evh   ? {8'h00, evcnt_reg[23:16]} :
      hit_set2  ? set2_reg :
      hit_crate ? {8'h00, crate_reg} : 16'h0000;

  wire logic [31:0] rdata_next = pend_reg             ? mem_q :
                                 (win_rd && empty)    ? fill_word :
                                 cfg_rd               ? {16'h0000, cfg_data} : 32'h00000000; // see RL2
  wire logic ack_next = pend_reg || (win_rd && empty) || cfg_rd || cfg_wr;
  wire logic pop_tail = pend_reg && (mem_q[`EBF_TYPE_MSB:`EBF_TYPE_LSB] == `EBF_TYPE_TAIL);

  // Pins pass two flops before any use.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aux_s1_reg  <= 1'b0;
      aux_s2_reg  <= 1'b0;
      pins_s1_reg <= 5'h00;
      pins_s2_reg <= 5'h00;
    end else begin
      aux_s1_reg  <= i_auxiliary_slot_connector;
      aux_s2_reg  <= aux_s1_reg;
      pins_s1_reg <= i_slot_pins;
      pins_s2_reg <= pins_s1_reg;
    end
  end

  // The slot address is captured once after reset, from the pins when the connector is there.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_cnt_reg  <= 2'h0;
      strap_done_reg <= 1'b0;
      slot_reg       <= `EBF_SLOT_RST;
    end else if (!strap_done_reg) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == `EBF_STRAP_WAIT) begin
        strap_done_reg <= 1'b1;
        if (aux_s2_reg) begin
          slot_reg <= pins_s2_reg;
        end
      end
    end else if (cfg_wr && slot_wr_ok) begin
      slot_reg <= i_bus.wdata[4:0]; // see RL18 see RL19
    end
  end

  // Configuration registers; multicast writes reach the same targets.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      crate_reg <= `EBF_CRATE_RST;
      set2_reg  <= `EBF_SET2_RST;
    end else if (cfg_wr) begin
      if (hit_crate) begin
        crate_reg <= i_bus.wdata[7:0];
      end
      if (hit_set2) begin
        set2_reg <= set2_reg | i_bus.wdata[15:0];
      end else if (hit_clr2) begin
        set2_reg <= set2_reg & ~i_bus.wdata[15:0];
      end
    end
  end

  // Event assembly registers.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fill_reg  <= FILL_IDLE;
      conv_reg  <= '0;
      off_reg   <= 32'h00000000;
      idx_reg   <= 5'h00;
      cnt_reg   <= 6'h00;
      evcnt_reg <= 24'h000000;
      wslot_reg <= '0;
    end else begin
      fill_reg  <= fill_next;
      wslot_reg <= wslot_next;
      if (accept) begin
        conv_reg <= i_conv;
        off_reg  <= i_chan_off;
        idx_reg  <= 5'h00;
        cnt_reg  <= 6'h00;
      end else if (fill_reg == FILL_SCAN && !scan_end) begin
        idx_reg <= idx_reg + 5'h01;
      end
      if (keep_now) begin
        cnt_reg <= cnt_reg + 6'h01; // see RL7 see RL16
      end
      // Events with no surviving channel store nothing but are still counted.
      if (commit || empty_event) begin
        evcnt_reg <= evcnt_reg + 24'h000001;
      end
    end
  end

  // Readout pointer and bus answers.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rslot_reg <= '0;
      rword_reg <= '0;
      pend_reg  <= 1'b0;
      rdata_reg <= 32'h00000000;
      ack_reg   <= 1'b0;
    end else begin
      pend_reg  <= win_rd && !empty;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
      if (pop_tail) begin
        rslot_reg <= rslot_reg + 1'b1;
        rword_reg <= '0;
      end else if (pend_reg) begin
        rword_reg <= rword_reg + 1'b1; // see RL25
      end
    end
  end

  // Ready is withheld while a slot is being built or no slot is free.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ready_reg  <= 1'b0;
      dready_reg <= 1'b0;
    end else begin
      ready_reg  <= (fill_next == FILL_IDLE) && !full_next && strap_done_reg;
      dready_reg <= !empty;
    end
  end

  assign o_rdata      = rdata_reg;
  assign o_ack        = ack_reg;
  assign o_conv_ready = ready_reg;
  assign o_data_ready = dready_reg;

endmodule : ebf_formatter

`default_nettype wire

// *** hw/ebf_map.svh ***
`ifndef EBF_MAP_SVH
`define EBF_MAP_SVH

// Register offsets from the module base.
`define EBF_OFS_WIN_FIRST  16'h0000
`define EBF_OFS_WIN_LAST   16'h07FC
`define EBF_OFS_WIN_END    16'h07FF
`define EBF_OFS_FW_REV     16'h1000
`define EBF_OFS_SLOT       16'h1002
`define EBF_OFS_STATUS1    16'h100E
`define EBF_OFS_EVCNT_LO   16'h1024
`define EBF_OFS_EVCNT_HI   16'h1026
`define EBF_OFS_SET2       16'h1032
`define EBF_OFS_CLR2       16'h1034
`define EBF_OFS_CRATE      16'h103C
`define EBF_OFS_MCST_FIRST 16'h1006
`define EBF_OFS_MCST_LAST  16'h10BF
`define EBF_OFS_ROM_FIRST  16'h8000

// Word type codes in bits 26 to 24.
`define EBF_TYPE_HEAD  3'h2
`define EBF_TYPE_DATA  3'h0
`define EBF_TYPE_TAIL  3'h4
`define EBF_TYPE_FILL  3'h6
`define EBF_TYPE_MSB   26
`define EBF_TYPE_LSB   24

// Bits of the second set-type control register.
`define EBF_SET2_OVF_KEEP   3
`define EBF_SET2_BELOW_KEEP 4

// Status register 1 bit positions.
`define EBF_ST1_READY   0
`define EBF_ST1_BUSY    2
`define EBF_ST1_MISSING 4

// Reset values.
`define EBF_SLOT_RST  5'h1F
`define EBF_CRATE_RST 8'h00
`define EBF_SET2_RST  16'h0000

// Buffer geometry: event slots of word slots each.
`define EBF_SLOT_BITS 4
`define EBF_WORD_BITS 6
`define EBF_ADDR_BITS 10

// Cycles after reset release before the slot pins are trusted.
`define EBF_STRAP_WAIT 2'h3

`endif

// *** hw/ebf_pkg.sv ***
`include "ebf_map.svh"

package ebf_pkg;

  typedef struct packed {
    logic [15:0] addr;
    logic [31:0] wdata;
    logic        rd;
    logic        wr;
    logic        chained;
    logic        mcst;
  } ebf_bus_req_t;

  typedef struct packed {
    logic              valid;
    logic [31:0]       ovf;
    logic [31:0]       below;
    logic [31:0][11:0] value;
  } ebf_conv_t;

  typedef struct packed {
    logic                      en;
    logic [`EBF_ADDR_BITS-1:0] addr;
    logic [31:0]               data;
  } ebf_mem_wr_t;

  typedef enum logic [1:0] {
    FILL_IDLE,
    FILL_SCAN,
    FILL_HEAD,
    FILL_TAIL
  } ebf_fill_st_t;

endpackage : ebf_pkg

// *** hw/ebf_word_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "ebf_map.svh"

module ebf_word_mem (
  // Clock
  input  wire logic                        i_clk,
  // Write port
  input  wire ebf_pkg::ebf_mem_wr_t        i_wr,
  // Read port
  input  wire logic [`EBF_ADDR_BITS-1:0]   i_raddr,
  output logic [31:0]                      o_rdata
);
  import ebf_pkg::*;

  logic [31:0] mem [0:(1<<`EBF_ADDR_BITS)-1];

  always_ff @(posedge i_clk) begin
    if (i_wr.en) begin
      mem[i_wr.addr] <= i_wr.data;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule : ebf_word_mem

`default_nettype wire

// *** testbench/ebf_formatter_chk.sv ***
`timescale 1ns/1ps
`default_nettype none

module ebf_formatter_chk
  import ebf_pkg::*;
#(
  parameter logic [15:0] FW_REVISION = 16'h0A17
) (
  // Clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_rst,
  // Watched ports
  input wire ebf_pkg::ebf_bus_req_t i_bus,
  input wire logic [31:0]           o_rdata,
  input wire logic                  o_ack,
  input wire ebf_pkg::ebf_conv_t    i_conv,
  input wire logic                  o_conv_ready,
  input wire logic                  i_auxiliary_slot_connector
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // A refused access must never be answered, or the master would not time out.
  sequence s_silent;
    !o_ack [*2];
  endsequence
  sequence s_fw_read;
    i_bus.rd && i_bus.addr == 16'h1000 && !i_bus.mcst && !i_bus.chained;
  endsequence

  fw_rev_a: assert property (s_fw_read |=> o_ack && o_rdata == {16'h0000, FW_REVISION})
    else $error("Revision read gave a wrong answer.");
  rom_ro_a: assert property (i_bus.wr && i_bus.addr >= 16'h8000 |=> s_silent)
    else $error("Write to configuration memory was answered.");
  win_ro_a: assert property (i_bus.wr && i_bus.addr <= 16'h07FF |=> s_silent)
    else $error("Write to the event window was answered.");
  chain_win_a: assert property (i_bus.rd && i_bus.chained && i_bus.addr > 16'h07FF |=> s_silent)
    else $error("Chained access outside the window was answered.");
  mcst_wo_a: assert property (i_bus.rd && i_bus.mcst |=> s_silent)
    else $error("Multicast read was answered.");
  slot_lock_a: assert property (i_bus.wr && i_bus.addr == 16'h1002 && i_auxiliary_slot_connector |=> s_silent)
    else $error("Slot write was answered with the connector present.");
  filler_word_a: assert property (o_ack && o_rdata[26:24] == 3'h6 |-> o_rdata == 32'h06000000)
    else $error("Filler word is malformed.");
  head_gap_a: assert property (o_ack && o_rdata[26:24] == 3'h2 |-> o_rdata[15:14] == 2'h0 && o_rdata[7:0] == 8'h00)
    else $error("Header has unassigned bits set.");
  ack_pulse_a: assert property (o_ack |=> !o_ack)
    else $error("Answer stood longer than one cycle.");
  idle_data_a: assert property (!o_ack |-> o_rdata == 32'h00000000)
    else $error("Read data shown without an answer.");
  conv_busy_a: assert property (i_conv.valid && o_conv_ready |=> !o_conv_ready [*8])
    else $error("Conversion port reopened before the event was built.");
endmodule : ebf_formatter_chk

bind ebf_formatter ebf_formatter_chk #(.FW_REVISION(FW_REVISION)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_bus(i_bus), .o_rdata(o_rdata), .o_ack(o_ack), .i_conv(i_conv),
  .o_conv_ready(o_conv_ready), .i_auxiliary_slot_connector(i_auxiliary_slot_connector));

`default_nettype wire

// *** testbench/ebf_bus_master.sv ***
`timescale 1ns/1ps
`default_nettype none

module ebf_bus_master (
  // Clock
  input wire logic                 i_clk,
  // Answer from the block
  input wire logic                 i_ack,
  input wire logic [31:0]          i_rdata,
  // Request to the block
  output var ebf_pkg::ebf_bus_req_t o_bus
);
  import ebf_pkg::*;

  initial o_bus = '0;

  // Strobes are single pulses; address and data are scrambled once taken so stale values cannot pass.
  task automatic access(input logic [15:0] a, input logic [31:0] d, input logic r, input logic ch,
                        input logic mc, output logic got, output logic [31:0] q);
    got = 1'b0;
    q = 32'h00000000;
    @(posedge i_clk);
    o_bus <= '{addr: a, wdata: d, rd: r, wr: ~r, chained: ch, mcst: mc};
    @(posedge i_clk);
    o_bus.rd <= 1'b0;
    o_bus.wr <= 1'b0;
    o_bus.addr <= ~a;
    o_bus.wdata <= ~d;
    for (int n = 0; n < 4 && !got; n++) begin
      @(posedge i_clk);
      if (i_ack === 1'b1) begin
        got = 1'b1;
        q = i_rdata;
      end
    end
  endtask : access
endmodule : ebf_bus_master

`default_nettype wire

// *** testbench/ebf_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin num_errors++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end

module tb;
  import ebf_pkg::*;
  // Arbitrary revision value.
  localparam logic [15:0] FW_REV = 16'h0B35;
  localparam logic [4:0]  SLOT   = 5'h0B;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         aux = 1'b1;
  ebf_bus_req_t bus;
  ebf_conv_t    conv = '0;
  logic [31:0]  chan_off = 32'hFFFF_FFFF;
  logic [31:0]  rdata;
  logic         ack, conv_ready, data_ready, got;
  logic [31:0]  q;
  int           num_errors = 0;
  int           tests_run = 0;
  int           cycles = 0;

  always #2.5 clk = ~clk;

  ebf_formatter #(.FULL_VARIANT(1'b1), .FW_REVISION(FW_REV)) uut (
    .i_clk(clk), .i_rst(rst), .i_bus(bus), .o_rdata(rdata), .o_ack(ack), .i_conv(conv),
    .i_chan_off(chan_off), .o_conv_ready(conv_ready), .i_auxiliary_slot_connector(aux),
    .i_slot_pins(SLOT), .o_data_ready(data_ready));
  ebf_bus_master master (.i_clk(clk), .i_ack(ack), .i_rdata(rdata), .o_bus(bus));

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] dw(input logic [4:0] ch, input logic un, input logic ov, input logic [11:0] v);
    return {SLOT, 3'h0, 3'h0, ch, 2'h0, un, ov, v};
  endfunction : dw

  task automatic rd_chk(input logic [15:0] a, input logic ch, input logic mc, input logic [32:0] e);
    master.access(a, 32'h0, 1'b1, ch, mc, got, q);
    `CHK({got, q}, e)
  endtask : rd_chk

  task automatic wr_chk(input logic [15:0] a, input logic [31:0] d, input logic mc, input logic e);
    master.access(a, d, 1'b0, 1'b0, mc, got, q);
    `CHK(got, e)
  endtask : wr_chk

  // Ready drops only at the edge that takes a conversion, so let one edge pass before trusting it.
  task automatic wait_ready;
    @(posedge clk);
    for (int n = 0; n < 200 && conv_ready !== 1'b1; n++) @(posedge clk);
  endtask : wait_ready

  task automatic t_regs;
    rd_chk(16'h1000, 1'b0, 1'b0, {1'b1, 16'h0000, FW_REV});
    rd_chk(16'h8000, 1'b0, 1'b0, {1'b1, 32'h0});
    rd_chk(16'h07FC, 1'b0, 1'b0, {1'b1, 32'h06000000});
    rd_chk(16'h0800, 1'b1, 1'b0, 33'h0);
    rd_chk(16'h103C, 1'b0, 1'b1, 33'h0);
    wr_chk(16'h8000, 32'h1, 1'b0, 1'b0);
    wr_chk(16'h0000, 32'h1, 1'b0, 1'b0);
    wr_chk(16'h1000, 32'h1, 1'b0, 1'b0);
    wr_chk(16'h1002, 32'h3, 1'b0, 1'b0);
    rd_chk(16'h1002, 1'b0, 1'b0, {1'b1, 27'h0, SLOT});
    wr_chk(16'h103C, 32'h5A, 1'b1, 1'b1);
    rd_chk(16'h103C, 1'b0, 1'b0, {1'b1, 24'h0, 8'h5A});
  endtask : t_regs

  // The second event runs with zero suppression back on, so its header count must shrink.
  task automatic t_events;
    wr_chk(16'h1032, 32'h18, 1'b0, 1'b1);
    for (int e = 0; e < 2; e++) begin
      wait_ready();
      if (e == 1) wr_chk(16'h1034, 32'h18, 1'b0, 1'b1);
      wait_ready();
      conv.valid <= 1'b1;
      @(posedge clk);
      conv.valid <= 1'b0;
    end
    wait_ready();
    `CHK(data_ready, 1'b1)
    for (int e = 0; e < 2; e++) begin
      rd_chk(16'h0000, 1'b0, 1'b0, {1'b1, SLOT, 3'h2, 8'h5A, 2'h0, 6'(e ? 2 : 4), 8'h00});
      rd_chk(16'h0004, 1'b0, 1'b0, {1'b1, dw(5'h00, 1'b0, 1'b0, 12'h123)});
      if (e == 0) rd_chk(16'h0008, 1'b0, 1'b0, {1'b1, dw(5'h10, 1'b1, 1'b0, 12'h456)});
      if (e == 0) rd_chk(16'h07FC, 1'b0, 1'b0, {1'b1, dw(5'h01, 1'b0, 1'b1, 12'h789)});
      rd_chk(16'h0010, 1'b0, 1'b0, {1'b1, dw(5'h02, 1'b0, 1'b0, 12'hFFF)});
      rd_chk(16'h0000, 1'b0, 1'b0, {1'b1, SLOT, 3'h4, 24'(e)});
    end
    rd_chk(16'h0000, 1'b0, 1'b0, {1'b1, 32'h06000000});
    `CHK(data_ready, 1'b0)
  endtask : t_events

  // Without the connector the master must supply the slot before chained readout.
  task automatic t_no_connector;
    rst <= 1'b1;
    aux <= 1'b0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk(16'h1002, 1'b0, 1'b0, {1'b1, 27'h0000000, 5'h1F});
    rd_chk(16'h100E, 1'b0, 1'b0, {1'b1, 16'h0000, 16'h0010});
    wr_chk(16'h1002, 32'h00000007, 1'b0, 1'b1);
    rd_chk(16'h1002, 1'b0, 1'b0, {1'b1, 27'h0000000, 5'h07});
    rd_chk(16'h0000, 1'b1, 1'b0, {1'b1, 32'h06000000});
    wait_ready();
    conv.valid <= 1'b1;
    @(posedge clk);
    conv.valid <= 1'b0;
    wait_ready();
    rd_chk(16'h0000, 1'b1, 1'b0, {1'b1, 5'h07, 3'h2, 8'h00, 2'h0, 6'h02, 8'h00});
    rd_chk(16'h0004, 1'b1, 1'b0, {1'b1, 5'h07, 27'h0000123});
  endtask : t_no_connector

  initial begin
    conv.value[0] <= 12'h123;
    conv.value[16] <= 12'h456;
    conv.below[16] <= 1'b1;
    conv.value[1] <= 12'h789;
    conv.ovf[1] <= 1'b1;
    conv.value[2] <= 12'hFFF;
    conv.value[17] <= 12'hABC;
    chan_off <= 32'hFFFE_FFF8;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    t_regs();
    t_events();
    t_no_connector();
    complete_run();
  end
endmodule : tb

`default_nettype wire
